/* File: hdl/cabe_alu8.sv */
// Purpose: 8-bit adder/subtractor with carry, half-carry and overflow
// Assumes: carry in is a borrow when subtracting
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cabe_alu8
  import cabe_pkg::*;
(
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic h_o,
  output logic v_o
);
  logic [8:0] full;
  logic [4:0] half;

  always_comb
  begin
    if (sub_i)
    begin
      full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
      half = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
    end
    else
    begin
      full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
      half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    end
    res_o = full[7:0];
    c_o = full[8];
    h_o = half[4];
    // Overflow: sign of result disagrees with what the operand signs allow
    if (sub_i)
      v_o = (a_i[7] & ~b_i[7] & ~full[7]) | (~a_i[7] & b_i[7] & full[7]);
    else
      v_o = (a_i[7] & b_i[7] & ~full[7]) | (~a_i[7] & ~b_i[7] & full[7]);
  end
endmodule
`default_nettype wire

/* File: hdl/cabe_cfg.svh */
// Purpose: constants of the execute datapath: flag positions, I/O space, cycle counts
// Assumes: one core clock, flags kept in an 8-bit status register
// Notes: included by the execute stage, the I/O bit module and the bench
`ifndef CABE_CFG_SVH
`define CABE_CFG_SVH

// Status register bit positions
`define CABE_FLAG_C 3'h0
`define CABE_FLAG_Z 3'h1
`define CABE_FLAG_N 3'h2
`define CABE_FLAG_V 3'h3
`define CABE_FLAG_S 3'h4
`define CABE_FLAG_H 3'h5
`define CABE_SREG_RESET 8'h00

// Bit-addressable I/O window
`define CABE_IO_FIRST 5'h00
`define CABE_IO_LAST 5'h1F
`define CABE_IO_DEPTH 32
`define CABE_IO_RESET 8'h00

// Registers whose flag bits clear on a written one, and which bits
`define CABE_W1C_ADDR_A 5'h0E
`define CABE_W1C_MASK_A 8'hE0
`define CABE_W1C_ADDR_B 5'h08
`define CABE_W1C_MASK_B 8'h10
`define CABE_W1C_ADDR_C 5'h06
`define CABE_W1C_MASK_C 8'h10

// Cycle counts per instruction class
`define CABE_CYC_ONE 2'h1
`define CABE_CYC_WORD 2'h2
`define CABE_CYC_JUMP 2'h2
`define CABE_CYC_CALL 2'h3
`define CABE_CYC_IOBIT 2'h2
`define CABE_CYC_SKIP1 2'h2
`define CABE_CYC_SKIP2 2'h3

// Mask constant for the clear-bits form
`define CABE_ALL_ONES 8'hFF

`endif

/* File: hdl/cabe_execute.sv */
// Purpose: execute stage: byte and word arithmetic, logic, compare, skip,
//          pointer jump and call, single-bit I/O access
// Assumes: request carries decoded op and operand values; one request
//          is taken per cycle while ready is high
// Notes: results, program counter loads and pushes are registered
`timescale 1ns/1ps
`default_nettype none
`include "cabe_cfg.svh"
// Behaviour
// RULE1: software writes reserved bits zero only
// RULE2: bit ops reach I/O addresses 0x00-0x1F
// RULE3: bit set/clear alters only addressed bit
// RULE4: some flags clear on written one
// RULE5: add, add-carry one cycle, ZCNVH
// RULE6: word add immediate two cycles, ZCNVS
// RULE7: word subtract immediate two cycles, ZCNVS
// RULE8: subtract, subtract-carry one cycle, ZCNVH
// RULE9: immediate subtract forms one cycle, ZCNVH
// RULE10: AND forms one cycle, ZNV only
// RULE11: OR forms and XOR, ZNV only
// RULE12: clear-bits ANDs with 0xFF minus mask
// RULE13: set-bits ORs mask, ZNV only
// RULE14: test ANDs register with itself, ZNV
// RULE15: pointer jump loads Z, two cycles
// RULE16: pointer call pushes, loads Z, three cycles
// RULE17: compare-skip advances 2 or 3, no flags
// RULE18: immediate compare stores nothing, ZNVCH
// RULE19: unnamed flags keep their values
module cabe_execute
  import cabe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire cabe_req_s req_i,
  output logic req_ready_o,
  output cabe_wb_s wb_o,
  output cabe_pc_s pc_load_o,
  output cabe_pc_s push_o,
  output logic [7:0] sreg_o,
  input wire logic io_evt_i,
  input wire logic [4:0] io_evt_addr_i,
  input wire logic [2:0] io_evt_bit_i,
  input wire logic [4:0] io_rd_addr_i,
  output logic [7:0] io_rd_data_o
);
  cabe_state_e state_r;
  cabe_state_e state_nxt;
  logic [1:0] hold_r;
  logic [1:0] hold_nxt;
  logic [7:0] sreg_r;
  logic [7:0] sreg_nxt;
  cabe_wb_s wb_r;
  cabe_wb_s wb_nxt;
  cabe_pc_s pcl_r;
  cabe_pc_s pcl_nxt;
  cabe_pc_s push_r;
  cabe_pc_s push_nxt;
  logic word_c_r;
  logic word_zl_r;
  logic word_sub_r;
  logic [7:0] word_hi_r;
  logic [4:0] word_idx_r;
  logic word_load;

  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_h;
  logic alu_v;
  logic [7:0] logic_res;
  logic io_we;
  logic io_val;
  logic [7:0] io_sel_data;
  logic take;
  logic cin;

  cabe_alu8 u_alu
  (
    .a_i(alu_a),
    .b_i(alu_b),
    .cin_i(alu_cin),
    .sub_i(alu_sub),
    .res_o(alu_res),
    .c_o(alu_c),
    .h_o(alu_h),
    .v_o(alu_v)
  );

  cabe_io_bits u_io
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .bit_we_i(io_we),
    .bit_val_i(io_val),
    .bit_addr_i(req_i.io_addr),
    .bit_sel_i(req_i.io_bit),
    .evt_i(io_evt_i),
    .evt_addr_i(io_evt_addr_i),
    .evt_bit_i(io_evt_bit_i),
    .rd_a_addr_i(req_i.io_addr),
    .rd_a_data_o(io_sel_data),
    .rd_b_addr_i(io_rd_addr_i),
    .rd_b_data_o(io_rd_data_o)
  );

  assign take = req_valid_i && (state_r == CABE_ST_IDLE);
  assign cin = sreg_r[`CABE_FLAG_C];
  assign req_ready_o = (state_r == CABE_ST_IDLE);
  assign wb_o = wb_r;
  assign pc_load_o = pcl_r;
  assign push_o = push_r;
  assign sreg_o = sreg_r;

  // Operand selection for the shared adder
  always_comb
  begin
    alu_a = req_i.rd_val;
    alu_b = req_i.rr_val;
    alu_cin = 1'b0;
    alu_sub = 1'b1;
    if (state_r == CABE_ST_WORD_HI)
    begin
      // High byte of a word op: only the carry from the low byte enters
      alu_a = word_hi_r;
      alu_b = 8'h00;
      alu_cin = word_c_r;
      alu_sub = word_sub_r;
    end
    else
    begin
      case (req_i.op)
        CABE_OP_ADD:
          alu_sub = 1'b0;
        CABE_OP_ADD_CARRY:
        begin
          alu_sub = 1'b0;
          alu_cin = cin;
        end
        CABE_OP_REG_SUBTRACT_CARRY, CABE_OP_COMPARE_WITH_CARRY:
          alu_cin = cin;
        CABE_OP_IMM_SUBTRACT, CABE_OP_COMPARE_IMMEDIATE:
          alu_b = req_i.imm;
        CABE_OP_IMM_SUBTRACT_CARRY:
        begin
          alu_b = req_i.imm;
          alu_cin = cin;
        end
        CABE_OP_WORD_ADD_IMMEDIATE:
        begin
          alu_b = req_i.imm;
          alu_sub = 1'b0;
        end
        CABE_OP_WORD_SUBTRACT_IMMEDIATE:
          alu_b = req_i.imm;
        default:
          alu_sub = 1'b1;
      endcase
    end
  end

  // Bitwise results
  always_comb
  begin
    case (req_i.op)
      // RULE10: AND with register or constant
      CABE_OP_AND:
        logic_res = req_i.rd_val & req_i.rr_val;
      CABE_OP_IMM_BITWISE_AND:
        logic_res = req_i.rd_val & req_i.imm;
      // RULE11: inclusive OR and exclusive OR
      CABE_OP_OR:
        logic_res = req_i.rd_val | req_i.rr_val;
      CABE_OP_IMM_BITWISE_OR:
        logic_res = req_i.rd_val | req_i.imm;
      CABE_OP_REG_BITWISE_XOR:
        logic_res = req_i.rd_val ^ req_i.rr_val;
      // RULE13: OR in the mask
      CABE_OP_MASK_BITS_SET:
        logic_res = req_i.rd_val | req_i.imm;
      // RULE12: complement mask as 0xFF minus mask
      CABE_OP_MASK_BITS_CLEAR:
        logic_res = req_i.rd_val & (`CABE_ALL_ONES - req_i.imm);
      // RULE14: register ANDed with itself
      CABE_OP_ZERO_MINUS_TEST:
        logic_res = req_i.rd_val & req_i.rd_val;
      default:
        logic_res = 8'h00;
    endcase
  end

  // Per-instruction effects; sreg_nxt starts from the held flags
  always_comb
  begin
    // RULE19: flags not named keep their value
    sreg_nxt = sreg_r;
    wb_nxt = '0;
    pcl_nxt = '0;
    push_nxt = '0;
    io_we = 1'b0;
    io_val = 1'b0;
    word_load = 1'b0;
    state_nxt = state_r;
    hold_nxt = hold_r;
    case (state_r)
      CABE_ST_IDLE:
      begin
        if (req_valid_i)
        begin
          case (req_i.op)
            // RULE5: byte add forms, one cycle
            // RULE8: byte subtract forms, one cycle
            // RULE9: immediate subtract forms, one cycle
            CABE_OP_ADD, CABE_OP_ADD_CARRY, CABE_OP_SUB, CABE_OP_REG_SUBTRACT_CARRY,
            CABE_OP_IMM_SUBTRACT, CABE_OP_IMM_SUBTRACT_CARRY:
            begin
              wb_nxt = '{valid: 1'b1, idx: req_i.rd_idx, data: alu_res};
              sreg_nxt[`CABE_FLAG_Z] = (alu_res == 8'h00);
              // Carry-in subtracts chain the zero flag across bytes
              if (req_i.op == CABE_OP_REG_SUBTRACT_CARRY ||
                  req_i.op == CABE_OP_IMM_SUBTRACT_CARRY)
                sreg_nxt[`CABE_FLAG_Z] = (alu_res == 8'h00) & sreg_r[`CABE_FLAG_Z];
              sreg_nxt[`CABE_FLAG_C] = alu_c;
              sreg_nxt[`CABE_FLAG_N] = alu_res[7];
              sreg_nxt[`CABE_FLAG_V] = alu_v;
              sreg_nxt[`CABE_FLAG_H] = alu_h;
            end
            // RULE18: compare forms set flags, store nothing
            CABE_OP_COMPARE, CABE_OP_COMPARE_WITH_CARRY, CABE_OP_COMPARE_IMMEDIATE:
            begin
              sreg_nxt[`CABE_FLAG_Z] = (alu_res == 8'h00);
              if (req_i.op == CABE_OP_COMPARE_WITH_CARRY)
                sreg_nxt[`CABE_FLAG_Z] = (alu_res == 8'h00) & sreg_r[`CABE_FLAG_Z];
              sreg_nxt[`CABE_FLAG_C] = alu_c;
              sreg_nxt[`CABE_FLAG_N] = alu_res[7];
              sreg_nxt[`CABE_FLAG_V] = alu_v;
              sreg_nxt[`CABE_FLAG_H] = alu_h;
            end
            // RULE6: word add, low byte now, high next cycle
            // RULE7: word subtract, same two-cycle split
            CABE_OP_WORD_ADD_IMMEDIATE, CABE_OP_WORD_SUBTRACT_IMMEDIATE:
            begin
              wb_nxt = '{valid: 1'b1, idx: req_i.rd_idx, data: alu_res};
              word_load = 1'b1;
              state_nxt = CABE_ST_WORD_HI;
            end
            CABE_OP_AND, CABE_OP_IMM_BITWISE_AND, CABE_OP_OR, CABE_OP_IMM_BITWISE_OR,
            CABE_OP_REG_BITWISE_XOR, CABE_OP_MASK_BITS_SET, CABE_OP_MASK_BITS_CLEAR,
            CABE_OP_ZERO_MINUS_TEST:
            begin
              wb_nxt = '{valid: 1'b1, idx: req_i.rd_idx, data: logic_res};
              sreg_nxt[`CABE_FLAG_Z] = (logic_res == 8'h00);
              sreg_nxt[`CABE_FLAG_N] = logic_res[7];
              sreg_nxt[`CABE_FLAG_V] = 1'b0;
            end
            // RULE17: skip past one- or two-word instruction
            CABE_OP_COMPARE_SKIP_EQUAL:
            begin
              if (req_i.rd_val == req_i.rr_val)
              begin
                pcl_nxt.valid = 1'b1;
                pcl_nxt.addr = req_i.next_two_word ? 16'(req_i.pc + 16'h0003) :
                                                     16'(req_i.pc + 16'h0002);
                hold_nxt = req_i.next_two_word ? `CABE_CYC_SKIP2 - 2'h1 :
                                                 `CABE_CYC_SKIP1 - 2'h1;
                state_nxt = CABE_ST_HOLD;
              end
            end
            CABE_OP_SKIP_IF_IO_BIT_ONE, CABE_OP_SKIP_IF_IO_BIT_ZERO:
            begin
              if (io_sel_data[req_i.io_bit] == (req_i.op == CABE_OP_SKIP_IF_IO_BIT_ONE))
              begin
                pcl_nxt.valid = 1'b1;
                pcl_nxt.addr = req_i.next_two_word ? 16'(req_i.pc + 16'h0003) :
                                                     16'(req_i.pc + 16'h0002);
                hold_nxt = req_i.next_two_word ? `CABE_CYC_SKIP2 - 2'h1 :
                                                 `CABE_CYC_SKIP1 - 2'h1;
                state_nxt = CABE_ST_HOLD;
              end
            end
            // RULE15: load pointer, two cycles
            CABE_OP_POINTER_JUMP:
            begin
              pcl_nxt = '{valid: 1'b1, addr: req_i.z_ptr};
              hold_nxt = `CABE_CYC_JUMP - 2'h1;
              state_nxt = CABE_ST_HOLD;
            end
            // RULE16: push return address, load pointer
            CABE_OP_POINTER_CALL:
            begin
              pcl_nxt = '{valid: 1'b1, addr: req_i.z_ptr};
              push_nxt = '{valid: 1'b1, addr: 16'(req_i.pc + 16'h0001)};
              hold_nxt = `CABE_CYC_CALL - 2'h1;
              state_nxt = CABE_ST_HOLD;
            end
            // RULE3: single-bit write, neighbours untouched
            CABE_OP_IO_BIT_SET, CABE_OP_IO_BIT_CLEAR:
            begin
              io_we = 1'b1;
              io_val = (req_i.op == CABE_OP_IO_BIT_SET);
              hold_nxt = `CABE_CYC_IOBIT - 2'h1;
              state_nxt = CABE_ST_HOLD;
            end
            default:
              state_nxt = CABE_ST_IDLE;
          endcase
        end
      end
      CABE_ST_WORD_HI:
      begin
        wb_nxt = '{valid: 1'b1, idx: 5'(word_idx_r + 5'h01), data: alu_res};
        sreg_nxt[`CABE_FLAG_Z] = word_zl_r & (alu_res == 8'h00);
        sreg_nxt[`CABE_FLAG_C] = alu_c;
        sreg_nxt[`CABE_FLAG_N] = alu_res[7];
        sreg_nxt[`CABE_FLAG_V] = alu_v;
        sreg_nxt[`CABE_FLAG_S] = alu_res[7] ^ alu_v;
        state_nxt = CABE_ST_IDLE;
      end
      CABE_ST_HOLD:
      begin
        hold_nxt = 2'(hold_r - 2'h1);
        if (hold_r == 2'h1)
          state_nxt = CABE_ST_IDLE;
      end
      default:
        state_nxt = CABE_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= CABE_ST_IDLE;
      hold_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Word op scratch: carry and zero of the low byte, operands of the high
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_c_r <= 1'b0;
      word_zl_r <= 1'b0;
      word_sub_r <= 1'b0;
      word_hi_r <= 8'h00;
      word_idx_r <= 5'h00;
    end
    else if (take && word_load)
    begin
      word_c_r <= alu_c;
      word_zl_r <= (alu_res == 8'h00);
      word_sub_r <= alu_sub;
      word_hi_r <= req_i.rdh_val;
      word_idx_r <= req_i.rd_idx;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      sreg_r <= `CABE_SREG_RESET;
    else
      sreg_r <= sreg_nxt;
  end

  // Outputs are one-cycle pulses, registered
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_r <= '0;
      pcl_r <= '0;
      push_r <= '0;
    end
    else
    begin
      wb_r <= wb_nxt;
      pcl_r <= pcl_nxt;
      push_r <= push_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/cabe_io_bits.sv */
// Purpose: low I/O space reachable by single-bit set, clear and test
// Assumes: peripherals raise flags through the event port
// Notes: some bits clear when a one is written; set by hardware wins
`timescale 1ns/1ps
`default_nettype none
`include "cabe_cfg.svh"
module cabe_io_bits
  import cabe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic bit_we_i,
  input wire logic bit_val_i,
  input wire logic [4:0] bit_addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic evt_i,
  input wire logic [4:0] evt_addr_i,
  input wire logic [2:0] evt_bit_i,
  input wire logic [4:0] rd_a_addr_i,
  output logic [7:0] rd_a_data_o,
  input wire logic [4:0] rd_b_addr_i,
  output logic [7:0] rd_b_data_o
);
  logic [7:0] io_mem_r [`CABE_IO_DEPTH];

  function automatic logic w1c_bit(input logic [4:0] addr, input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (addr == `CABE_W1C_ADDR_A)
      m = `CABE_W1C_MASK_A;
    if (addr == `CABE_W1C_ADDR_B)
      m = `CABE_W1C_MASK_B;
    if (addr == `CABE_W1C_ADDR_C)
      m = `CABE_W1C_MASK_C;
    return m[sel];
  endfunction

  assign rd_a_data_o = io_mem_r[rd_a_addr_i];
  assign rd_b_data_o = io_mem_r[rd_b_addr_i];

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `CABE_IO_DEPTH; i++)
        io_mem_r[i] <= `CABE_IO_RESET;
    end
    else
    begin
      for (int i = 0; i < `CABE_IO_DEPTH; i++)
      begin
        for (int b = 0; b < 8; b++)
        begin
          // RULE2: every address of the window is bit-addressable
          if (bit_we_i && bit_addr_i == 5'(i) && bit_sel_i == 3'(b))
          begin
            // RULE4: one written to a flag clears it
            if (w1c_bit(5'(i), 3'(b)))
            begin
              if (bit_val_i)
                io_mem_r[i][b] <= 1'b0;
            end
            else
              io_mem_r[i][b] <= bit_val_i;
          end
          // Hardware event last so it beats a same-cycle clear
          if (evt_i && evt_addr_i == 5'(i) && evt_bit_i == 3'(b))
            io_mem_r[i][b] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/cabe_pkg.sv */
// Purpose: types shared by the execute datapath modules
// Assumes: constants live in cabe_cfg.svh
// Notes: the request is already decoded and carries register operands read out
package cabe_pkg;

  typedef enum logic [4:0] {
    CABE_OP_ADD,
    CABE_OP_ADD_CARRY,
    CABE_OP_SUB,
    CABE_OP_REG_SUBTRACT_CARRY,
    CABE_OP_IMM_SUBTRACT,
    CABE_OP_IMM_SUBTRACT_CARRY,
    CABE_OP_WORD_ADD_IMMEDIATE,
    CABE_OP_WORD_SUBTRACT_IMMEDIATE,
    CABE_OP_AND,
    CABE_OP_IMM_BITWISE_AND,
    CABE_OP_OR,
    CABE_OP_IMM_BITWISE_OR,
    CABE_OP_REG_BITWISE_XOR,
    CABE_OP_MASK_BITS_SET,
    CABE_OP_MASK_BITS_CLEAR,
    CABE_OP_ZERO_MINUS_TEST,
    CABE_OP_COMPARE,
    CABE_OP_COMPARE_WITH_CARRY,
    CABE_OP_COMPARE_IMMEDIATE,
    CABE_OP_COMPARE_SKIP_EQUAL,
    CABE_OP_POINTER_JUMP,
    CABE_OP_POINTER_CALL,
    CABE_OP_IO_BIT_SET,
    CABE_OP_IO_BIT_CLEAR,
    CABE_OP_SKIP_IF_IO_BIT_ONE,
    CABE_OP_SKIP_IF_IO_BIT_ZERO
  } cabe_op_e;

  typedef struct packed {
    cabe_op_e op;
    logic [4:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] rdh_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [4:0] io_addr;
    logic [2:0] io_bit;
    logic [15:0] pc;
    logic [15:0] z_ptr;
    logic next_two_word;
  } cabe_req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [7:0] data;
  } cabe_wb_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } cabe_pc_s;

  typedef enum logic [1:0] {
    CABE_ST_IDLE,
    CABE_ST_WORD_HI,
    CABE_ST_HOLD
  } cabe_state_e;

endpackage

/* File: sim/cabe_execute_properties.sv */
// Purpose: port-level properties of the execute stage
// Assumes: single core clock, asynchronous active-high reset
// Notes: bound to every cabe_execute instance
`timescale 1ns/1ps
`default_nettype none
module cabe_execute_properties
  import cabe_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire cabe_req_s req_i,
  input wire logic req_ready_o,
  input wire cabe_wb_s wb_o,
  input wire cabe_pc_s pc_load_o,
  input wire cabe_pc_s push_o,
  input wire logic [7:0] sreg_o,
  input wire logic io_evt_i,
  input wire logic [4:0] io_evt_addr_i,
  input wire logic [2:0] io_evt_bit_i,
  input wire logic [4:0] io_rd_addr_i,
  input wire logic [7:0] io_rd_data_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = req_valid_i && req_ready_o;

  chk_add_result: assert property (
    take && req_i.op == CABE_OP_ADD |=> wb_o.valid && req_ready_o
      && wb_o.data == 8'($past(req_i.rd_val) + $past(req_i.rr_val)))
    else $error("add result or timing wrong");
  chk_logic_flags: assert property (
    take && req_i.op inside {[CABE_OP_AND:CABE_OP_ZERO_MINUS_TEST]}
    |=> !sreg_o[3] && sreg_o[1] == (wb_o.data == 8'h00)
      && $stable({sreg_o[5:4], sreg_o[0]}))
    else $error("logic op flags wrong");
  chk_word_timing: assert property (
    take && req_i.op inside {CABE_OP_WORD_ADD_IMMEDIATE, CABE_OP_WORD_SUBTRACT_IMMEDIATE}
    |=> wb_o.valid && !req_ready_o ##1 wb_o.valid && req_ready_o
      && wb_o.idx == 5'($past(req_i.rd_idx, 2) + 5'h01))
    else $error("word op not two cycles");
  chk_jump_load: assert property (
    take && req_i.op == CABE_OP_POINTER_JUMP |=> pc_load_o.valid && !push_o.valid
      && pc_load_o.addr == $past(req_i.z_ptr) && $stable(sreg_o) && !req_ready_o
      ##1 req_ready_o)
    else $error("pointer jump wrong");
  chk_call_push: assert property (
    take && req_i.op == CABE_OP_POINTER_CALL |=> push_o.valid && pc_load_o.valid
      && push_o.addr == 16'($past(req_i.pc) + 16'h0001) && $stable(sreg_o)
      && !req_ready_o ##1 !req_ready_o ##1 req_ready_o)
    else $error("pointer call wrong");
  chk_skip_equal: assert property (
    take && req_i.op == CABE_OP_COMPARE_SKIP_EQUAL && req_i.rd_val == req_i.rr_val
    |=> pc_load_o.valid && $stable(sreg_o) && !wb_o.valid && pc_load_o.addr
      == 16'($past(req_i.pc) + ($past(req_i.next_two_word) ? 16'h0003 : 16'h0002)))
    else $error("equal skip wrong");
  chk_cmp_nostore: assert property (
    take && req_i.op == CABE_OP_COMPARE_IMMEDIATE |=> !wb_o.valid && req_ready_o
      && sreg_o[1] == ($past(req_i.rd_val) == $past(req_i.imm))
      && sreg_o[0] == ($past(req_i.rd_val) < $past(req_i.imm)))
    else $error("immediate compare wrong");
  chk_iobit_cycles: assert property (
    take && req_i.op inside {CABE_OP_IO_BIT_SET, CABE_OP_IO_BIT_CLEAR}
    |=> !req_ready_o ##1 req_ready_o)
    else $error("io bit op not two cycles");
  chk_evt_sets: assert property (
    io_evt_i ##1 io_rd_addr_i == $past(io_evt_addr_i) |-> io_rd_data_o[$past(io_evt_bit_i)])
    else $error("io event bit not set");
endmodule
bind cabe_execute cabe_execute_properties u_props (.*);
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the execute stage
// Assumes: bench drives requests and I/O events itself
// Notes: expected values come from an integer model
`timescale 1ns/1ps
`default_nettype none
`include "cabe_cfg.svh"
module tb_top
  import cabe_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  cabe_req_s req_i = '0;
  logic io_evt_i = 1'b0;
  logic [4:0] io_evt_addr_i = 5'h00;
  logic [2:0] io_evt_bit_i = 3'h0;
  logic [4:0] io_rd_addr_i = 5'h00;
  logic req_ready_o;
  cabe_wb_s wb_o;
  cabe_pc_s pc_load_o;
  cabe_pc_s push_o;
  logic [7:0] sreg_o;
  logic [7:0] io_rd_data_o;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 44303;
  logic [7:0] sreg_m = 8'h00;
  logic [7:0] io_m [32];
  logic [4:0] lut [4] = '{`CABE_W1C_ADDR_A, `CABE_W1C_ADDR_B, `CABE_W1C_ADDR_C, `CABE_IO_LAST};
  cabe_wb_s ew;
  cabe_pc_s ep;
  cabe_pc_s eh;
  logic [15:0] w16;
  logic [95:0] rv;
  cabe_req_s r;

  always #20 mclk_i = ~mclk_i;

  cabe_execute dut (.*);

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Data fields of an idle write-back or PC-load pulse are left open, so only valid is compared then; push is compared whole
  task automatic chk_out();
    chk(32'(wb_o.valid), 32'(ew.valid));
    if (ew.valid)
      chk(32'(wb_o), 32'(ew));
    chk(32'(pc_load_o.valid), 32'(ep.valid));
    if (ep.valid)
      chk(32'(pc_load_o), 32'(ep));
    chk(32'(push_o), 32'(eh));
    chk(32'(sreg_o), 32'(sreg_m));
  endtask

  function automatic logic [7:0] w1c(input logic [4:0] a);
    return a == `CABE_W1C_ADDR_A ? `CABE_W1C_MASK_A : a == `CABE_W1C_ADDR_B ? `CABE_W1C_MASK_B
      : a == `CABE_W1C_ADDR_C ? `CABE_W1C_MASK_C : 8'h00;
  endfunction

  task automatic model(input cabe_req_s q);
    logic [7:0] a, b, res, m;
    logic sub, cfo, cf, tk;
    int full;
    a = q.rd_val;
    b = q.op inside {CABE_OP_IMM_SUBTRACT, CABE_OP_IMM_SUBTRACT_CARRY, CABE_OP_IMM_BITWISE_AND,
      CABE_OP_IMM_BITWISE_OR, CABE_OP_MASK_BITS_SET, CABE_OP_MASK_BITS_CLEAR,
      CABE_OP_COMPARE_IMMEDIATE} ? q.imm : q.rr_val;
    sub = q.op inside {[CABE_OP_SUB:CABE_OP_IMM_SUBTRACT_CARRY],
      [CABE_OP_COMPARE:CABE_OP_COMPARE_IMMEDIATE]};
    cfo = q.op inside {CABE_OP_ADD_CARRY, CABE_OP_REG_SUBTRACT_CARRY, CABE_OP_IMM_SUBTRACT_CARRY,
      CABE_OP_COMPARE_WITH_CARRY};
    cf = cfo && sreg_m[0];
    m = w1c(q.io_addr);
    ew = '0;
    ep = '0;
    eh = '0;
    res = 8'h00;
    tk = (q.op == CABE_OP_COMPARE_SKIP_EQUAL && a == q.rr_val)
      || (q.op == CABE_OP_SKIP_IF_IO_BIT_ONE && io_m[q.io_addr][q.io_bit])
      || (q.op == CABE_OP_SKIP_IF_IO_BIT_ZERO && !io_m[q.io_addr][q.io_bit]);
    if (tk)
      ep = '{1'b1, 16'(q.pc + (q.next_two_word ? 16'h0003 : 16'h0002))};
    case (q.op)
      CABE_OP_AND, CABE_OP_IMM_BITWISE_AND: res = a & b;
      CABE_OP_ZERO_MINUS_TEST: res = a & a;
      CABE_OP_OR, CABE_OP_IMM_BITWISE_OR, CABE_OP_MASK_BITS_SET: res = a | b;
      CABE_OP_REG_BITWISE_XOR: res = a ^ b;
      CABE_OP_MASK_BITS_CLEAR: res = a & (8'hFF - b);
      CABE_OP_POINTER_JUMP, CABE_OP_POINTER_CALL: ep = '{1'b1, q.z_ptr};
      CABE_OP_IO_BIT_SET: io_m[q.io_addr][q.io_bit] = !m[q.io_bit];
      default: res = 8'h00;
    endcase
    if (q.op == CABE_OP_POINTER_CALL)
      eh = '{1'b1, 16'(q.pc + 16'h0001)};
    if (q.op == CABE_OP_IO_BIT_CLEAR && !m[q.io_bit])
      io_m[q.io_addr][q.io_bit] = 1'b0;
    if (q.op inside {[CABE_OP_AND:CABE_OP_ZERO_MINUS_TEST]})
    begin
      sreg_m[3:1] = {1'b0, res[7], res == 8'h00};
      ew = '{1'b1, q.rd_idx, res};
    end
    if (sub || q.op <= CABE_OP_ADD_CARRY)
    begin
      full = sub ? int'(a) - int'(b) - cf : int'(a) + int'(b) + cf;
      res = full[7:0];
      sreg_m[5] = sub ? int'(b[3:0]) + cf > int'(a[3:0]) : int'(a[3:0]) + b[3:0] + cf > 15;
      sreg_m[3] = sub ? a[7] != b[7] && res[7] != a[7] : a[7] == b[7] && res[7] != a[7];
      sreg_m[2] = res[7];
      sreg_m[1] = res == 8'h00 && (!(sub && cfo) || sreg_m[1]);
      sreg_m[0] = full > 255 || full < 0;
      if (q.op < CABE_OP_COMPARE)
        ew = '{1'b1, q.rd_idx, res};
    end
    if (q.op inside {CABE_OP_WORD_ADD_IMMEDIATE, CABE_OP_WORD_SUBTRACT_IMMEDIATE})
    begin
      full = q.op == CABE_OP_WORD_ADD_IMMEDIATE ? int'({q.rdh_val, a}) + q.imm
        : int'({q.rdh_val, a}) - int'(q.imm);
      w16 = full[15:0];
      sreg_m[3] = q.op == CABE_OP_WORD_ADD_IMMEDIATE ? !q.rdh_val[7] && w16[15]
        : q.rdh_val[7] && !w16[15];
      sreg_m[2:0] = {w16[15], w16 == 16'h0000, full > 65535 || full < 0};
      sreg_m[4] = w16[15] ^ sreg_m[3];
      ew = '{1'b1, q.rd_idx, w16[7:0]};
    end
  endtask

  // Request is held until the edge that finds ready high
  task automatic issue(input cabe_req_s q);
    int k;
    k = 0;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_i <= q;
    io_rd_addr_i <= q.io_addr;
    @(negedge mclk_i);
    while (req_ready_o !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        error_cnt++;
        $display("Error at %0t: request never taken", $time);
        final_report();
      end
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic pulse_evt(input logic [4:0] a, input logic [2:0] b);
    @(posedge mclk_i);
    io_evt_i <= 1'b1;
    io_evt_addr_i <= a;
    io_evt_bit_i <= b;
    io_rd_addr_i <= a;
    @(posedge mclk_i);
    io_evt_i <= 1'b0;
    io_m[a][b] = 1'b1;
  endtask

  task automatic sweep();
    for (int a = 0; a < 32; a++)
    begin
      @(posedge mclk_i);
      io_rd_addr_i <= 5'(a);
      @(negedge mclk_i);
      chk(32'(io_rd_data_o), 32'(io_m[a]));
    end
  endtask

  initial
  begin
    for (int i = 0; i < 32; i++)
      io_m[i] = 8'h00;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    sweep();
    chk(32'(sreg_o), 32'(`CABE_SREG_RESET));
    for (int i = 0; i < 600; i++)
    begin
      rv = {$random(seed), $random(seed), $random(seed)};
      r = rv[82:0];
      r.op = cabe_op_e'(($random(seed) & 32'h7FFF) % 26);
      if (i % 4 == 0)
        r.rr_val = r.rd_val;
      // even requests aim at the write-one-to-clear registers or the last I/O address
      if (i % 2 == 0)
        r.io_addr = lut[i % 8 / 2];
      if (i % 3 == 0)
        pulse_evt(r.io_addr, 3'($random(seed)));
      model(r);
      issue(r);
      if (r.op inside {CABE_OP_WORD_ADD_IMMEDIATE, CABE_OP_WORD_SUBTRACT_IMMEDIATE})
      begin
        chk(32'(wb_o), 32'(ew));
        ew = '{1'b1, 5'(r.rd_idx + 5'h01), w16[15:8]};
        @(negedge mclk_i);
      end
      chk_out();
      chk(32'(io_rd_data_o), 32'(io_m[r.io_addr]));
    end
    sweep();
    final_report();
  end
endmodule
`default_nettype wire
